// ===== dsl_cfg.svh
/*
  Timing and code constants for the slave data lane control block.
  Assumes a 200 MHz device clock; every duration is kept in ns and
  converted to whole device-clock cycles here.
*/
`ifndef DSL_CFG_SVH
`define DSL_CFG_SVH

// ==========================================================
// Clock and durations
`define DSL_CLK_NS 5
`define DSL_LP_STATE_MIN_TIME_NS 50
`define DSL_T_TERM_EN_NS 35
`define DSL_T_SETTLE_NS 145
`define DSL_T_SKIP_NS 40
`define DSL_T_WAKEUP_NS 1000000
`define DSL_T_INIT_NS 500000

// Least times round up to whole cycles
`define DSL_CYC_UP(ns) (((ns) + `DSL_CLK_NS - 1) / `DSL_CLK_NS)
`define DSL_LPX_CYC `DSL_CYC_UP(`DSL_LP_STATE_MIN_TIME_NS)
`define DSL_TERM_EN_CYC `DSL_CYC_UP(`DSL_T_TERM_EN_NS)
`define DSL_SETTLE_CYC `DSL_CYC_UP(`DSL_T_SETTLE_NS)
`define DSL_SKIP_CYC `DSL_CYC_UP(`DSL_T_SKIP_NS)
`define DSL_WAKEUP_CYC `DSL_CYC_UP(`DSL_T_WAKEUP_NS)
// Initialization must exceed the time, so one cycle more
`define DSL_INIT_CYC (`DSL_CYC_UP(`DSL_T_INIT_NS) + 1)

// ==========================================================
// Line levels {dp, dn}
`define DSL_LP_STOP 2'b11
`define DSL_LP_MARK1 2'b10
`define DSL_LP_MARK0 2'b01
`define DSL_LP_SPACE 2'b00

// ==========================================================
// Entry commands, bit 7 is the first bit on the wire
`define DSL_CMD_LPDT 8'he1
`define DSL_CMD_ULPS 8'h1e
`define DSL_CMD_RESET 8'h62
`define DSL_CMD_TE 8'h5d
`define DSL_CMD_ACK 8'h21
// HS leader, oldest bit in bit 5
`define DSL_HS_LEADER 6'h1d

// ==========================================================
// Transmit phase indexes
`define DSL_TX_PH_BITS 5'h04
`define DSL_TX_PH_MARK1 5'h14
`define DSL_TX_PH_STOP 5'h15

`endif

// ===== dsl_host_model.sv
/*
  Host transmitter model of one data lane: LP levels and HS bursts.
  Assumes every task is entered at a falling edge of the device clock.
*/
`timescale 1ns/100ps
// ==========================================================
// Host lane driver
module dsl_host_model #(
  parameter int LPX = 14
) (
  input wire logic clk,
  output logic dp,
  output logic dn,
  output logic link_clk,
  output logic hs_data
);
  localparam logic [7:0] SYNC = 8'h1d;
  // Stop at power-up; link clock stands still outside bursts
  initial begin
    {dp, dn} = 2'b11;
    link_clk = 1'b0;
    hs_data = 1'b0;
  end
  // One LP state held for n cycles
  task automatic lp(input logic [1:0] s, input int n);
    {dp, dn} = s;
    repeat (n) @(negedge clk);
  endtask : lp
  // Mark then space carries one bit
  task automatic sym(input logic b);
    lp(b ? 2'b10 : 2'b01, LPX);
    lp(2'b00, LPX);
  endtask : sym
  // Escape entry, then the command first bit first
  task automatic esc(input logic [7:0] c);
    int i;
    lp(2'b11, LPX);
    lp(2'b10, LPX);
    lp(2'b00, LPX);
    lp(2'b01, LPX);
    lp(2'b00, LPX);
    for (i = 7; i >= 0; i--) sym(c[i]);
  endtask : esc
  // LPDT bytes go out LSB first
  task automatic lsb(input logic [7:0] d);
    int i;
    for (i = 0; i < 8; i++) sym(d[i]);
  endtask : lsb
  // Closing mark-one that carries no bit, then a long stop
  task automatic fin();
    lp(2'b10, LPX);
    lp(2'b11, 3 * LPX);
  endtask : fin
  // Rising link edge sits mid-bit, so data and clock are in quadrature
  task automatic hbit(input logic b);
    hs_data = b;
    #32 link_clk = 1'b1;
    #32 link_clk = 1'b0;
  endtask : hbit
  // Request, bridge, zeros, sync, two bytes, trail, stop
  task automatic burst(input logic [15:0] w);
    int i;
    lp(2'b01, LPX);
    lp(2'b00, LPX);
    #1.3;
    repeat (24) hbit(1'b0);
    for (i = 7; i >= 0; i--) hbit(SYNC[i]);
    for (i = 0; i < 16; i++) hbit(w[i]);
    repeat (8) hbit(~w[15]);
    @(negedge clk);
    lp(2'b11, 4 * LPX);
  endtask : burst
endmodule : dsl_host_model

// ===== dsl_hs_rx.sv
/*
  High-speed deserialiser of one data lane, running on the link bit
  clock. Assumes one data bit per rising edge of link_clk (the forwarded
  DDR clock already doubled outside) and that hs_en and reset come
  registered from the device clock domain. The link clock may stand
  still through reset, so reset is taken in asynchronously here.
*/
`timescale 1ns/100ps
`include "dsl_cfg.svh"

module dsl_hs_rx (
  input wire logic link_clk,
  input wire logic reset,
  input wire logic hs_en,
  input wire logic hs_data,
  output logic [7:0] byte_data,
  output logic byte_tog
);
  import dsl_pkg::*;

  logic en_s1_r, en_s2_r, rst_s1_r, rst_s2_r;
  logic synced_r;
  logic [5:0] hunt_r;
  logic [7:0] sh_r;
  logic [2:0] cnt_r;
  wire run = en_s2_r && !rst_s2_r;
  wire [5:0] hunt_nxt = {hunt_r[4:0], hs_data};
  wire leader_hit = (hunt_nxt == `DSL_HS_LEADER);

  // ==========================================================
  // Level crossings; reset asserts at once, leaves on link edges only
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      en_s1_r <= 1'b0;
      en_s2_r <= 1'b0;
      rst_s1_r <= 1'b1;
      rst_s2_r <= 1'b1;
    end else begin
      en_s1_r <= hs_en;
      en_s2_r <= en_s1_r;
      rst_s1_r <= 1'b0;
      rst_s2_r <= rst_s1_r;
    end
  end

  // Leader hunt, then bytes LSB first; a whole byte flips the toggle
  always_ff @(posedge link_clk) begin
    if (!run) begin
      synced_r <= 1'b0;
      hunt_r <= 6'h00;
      cnt_r <= 3'h0;
    end else if (!synced_r) begin
      hunt_r <= hunt_nxt;
      synced_r <= leader_hit;
    end else begin
      sh_r <= {hs_data, sh_r[7:1]};
      cnt_r <= cnt_r + 3'h1;
    end
  end

  // Byte held stable for eight bit times while the toggle crosses
  always_ff @(posedge link_clk or posedge rst_s2_r) begin
    if (rst_s2_r) begin
      byte_tog <= 1'b0;
      byte_data <= 8'h00;
    end else if (run && synced_r && cnt_r == 3'h7) begin
      byte_data <= {hs_data, sh_r[7:1]};
      byte_tog <= !byte_tog;
    end
  end

endmodule : dsl_hs_rx

// ===== dsl_lane_ctrl.sv
/*
  Slave side control of one bidirectional data lane: initialization,
  escape entry, LPDT, ULPS, triggers, HS burst start and end, and the
  reverse escape sequences for acknowledge and tearing events.
  Assumes LP line levels arrive asynchronously, the HS bit clock is a
  separate domain, and turnaround itself is handled outside.
*/
`timescale 1ns/100ps
`include "dsl_cfg.svh"

// Function
// - after a trigger command, ignore all bits until stop state.
// - LPDT bits use the same spaced one-hot code as entry commands.
// - space held during LPDT is a pause, never a bit or an error.
// - stop during LPDT ends it and returns the lane to control mode.
// - the closing mark-one before stop carries no data bit.
// - ULPS command enters ULPS with lines low and flags the protocol.
// - leave ULPS only after a wakeup-long mark-one then a stop.
// - a command with turnaround gets an acknowledge, then bus is returned.
// - tearing event while owning bus: escape, send TE trigger, return bus.
// - the TE trigger code means tearing only, nothing else.
// - each burst carries a whole number of bytes, at least one.
// - termination after its delay, then ignore lines until settle expires.
// - byte alignment on leader 011101; following bits are payload.
// - on stop after burst, drop termination, skip bits and trailer.
// - initialization completes on first stop longer than init time.
// - each lane starts and ends its burst on its own.
// - escape entry sequence; a stop before final bridge aborts it.
// - LPDT command 11100001 and ULPS command 00011110, first bit first.
// - mark then space is a bit; a mark without space is none.
// - a stop held the minimum time returns to stop from any state; here INIT, TX and ULPS are exempt.
module dsl_lane_ctrl #(
  parameter int LPX_CYC = `DSL_LPX_CYC,
  parameter int TERM_EN_CYC = `DSL_TERM_EN_CYC,
  parameter int SETTLE_CYC = `DSL_SETTLE_CYC,
  parameter int SKIP_CYC = `DSL_SKIP_CYC,
  parameter int WAKEUP_CYC = `DSL_WAKEUP_CYC,
  parameter int INIT_CYC = `DSL_INIT_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic dp_i,
  input wire logic dn_i,
  output dsl_pkg::dsl_lp_drv_t lp_drv,
  input wire logic link_clk,
  input wire logic hs_data,
  output logic term_en,
  input wire logic bus_owned,
  input wire logic ack_req,
  input wire logic te_event,
  output logic bus_return,
  output dsl_pkg::dsl_rx_t rx_o,
  output logic init_done,
  output logic ulps_active,
  output logic ulps_enter,
  output logic trig_reset
);
  import dsl_pkg::*;

  // ==========================================================
  // Line synchronisers and stop detection
  logic dp_s1_r, dp_s2_r, dn_s1_r, dn_s2_r;
  logic [7:0] stop_cnt_r;
  logic [19:0] init_cnt_r;
  wire [1:0] lp = {dp_s2_r, dn_s2_r};
  wire is_stop = (lp == `DSL_LP_STOP);
  wire is_space = (lp == `DSL_LP_SPACE);
  wire is_mark = (lp == `DSL_LP_MARK0) || (lp == `DSL_LP_MARK1);
  wire stop_long = is_stop && (stop_cnt_r == 8'h00);

  always_ff @(posedge clk) begin
    dp_s1_r <= dp_i;
    dp_s2_r <= dp_s1_r;
    dn_s1_r <= dn_i;
    dn_s2_r <= dn_s1_r;
  end

  // Stop and init durations, reloaded whenever the lines leave LP-11
  always_ff @(posedge clk) begin
    if (reset || (ce && !is_stop)) begin
      stop_cnt_r <= 8'(LPX_CYC - 1);
      init_cnt_r <= 20'(INIT_CYC - 1);
    end else if (ce) begin
      if (stop_cnt_r != 8'h00) stop_cnt_r <= stop_cnt_r - 8'h01;
      if (init_cnt_r != 20'h0) init_cnt_r <= init_cnt_r - 20'h1;
    end
  end

  // ==========================================================
  // Receive state machine
  dsl_state_t st_r, st_nxt;
  logic [19:0] cnt_r, cnt_nxt;
  logic mark_r, mark_val_r, first_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] sh_r;
  logic tx_act_r, tx_done;
  logic ack_pend_r, te_pend_r;
  wire sym_bit = is_space && mark_r;
  wire [7:0] cur_byte = {sh_r[6:0], mark_val_r};
  wire byte_done = sym_bit && (bit_cnt_r == 4'h7);
  wire cnt_zero = (cnt_r == 20'h0);
  wire tx_start = (st_r == ST_STOP) && bus_owned && (ack_pend_r || te_pend_r);
  logic [7:0] cur_rev;

  // LPDT payload goes out LSB first on the wire, so reverse the shifter
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_rev
      assign cur_rev[gi] = cur_byte[7 - gi];
    end
  endgenerate

  // Next state; stop from anywhere except INIT, TX and ULPS, which needs the wakeup mark
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_zero ? 20'h0 : cnt_r - 20'h1;
    case (st_r)
      ST_INIT: if (is_stop && init_cnt_r == 20'h0) st_nxt = ST_STOP;
      ST_STOP: begin
        if (tx_start) begin
          st_nxt = ST_TX;
        end else if (lp == `DSL_LP_MARK0) begin
          st_nxt = ST_HS_RQST;
        end else if (lp == `DSL_LP_MARK1) begin
          st_nxt = ST_ESC_RQST;
        end
      end
      ST_HS_RQST: begin
        if (is_space) begin
          st_nxt = ST_HS_PREP;
          cnt_nxt = 20'(TERM_EN_CYC - 1);
        end else if (is_stop) begin
          st_nxt = ST_STOP;
        end
      end
      ST_HS_PREP: begin
        if (cnt_zero) begin
          st_nxt = ST_HS_SETTLE;
          cnt_nxt = 20'(SETTLE_CYC - 1);
        end
      end
      ST_HS_SETTLE: if (cnt_zero) st_nxt = ST_HS_RX;
      ST_HS_RX: if (stop_long) st_nxt = ST_STOP;
      ST_ESC_RQST: begin
        if (is_stop) st_nxt = ST_STOP;
        else if (is_space) st_nxt = ST_ESC_BRIDGE;
      end
      ST_ESC_BRIDGE: begin
        if (is_stop) st_nxt = ST_STOP;
        else if (lp == `DSL_LP_MARK0) st_nxt = ST_ESC_MARK0;
      end
      ST_ESC_MARK0: begin
        if (is_stop) st_nxt = ST_STOP;
        else if (is_space) st_nxt = ST_ESC_CMD;
      end
      ST_ESC_CMD: begin
        if (stop_long) begin
          st_nxt = ST_STOP;
        end else if (byte_done) begin
          if (cur_byte == `DSL_CMD_LPDT) begin
            st_nxt = ST_LPDT;
          end else if (cur_byte == `DSL_CMD_ULPS) begin
            st_nxt = ST_ULPS;
          end else begin
            st_nxt = ST_TRIG_SKIP;
          end
        end
      end
      ST_LPDT: if (stop_long) st_nxt = ST_STOP;
      ST_TRIG_SKIP: if (stop_long) st_nxt = ST_STOP;
      ST_ULPS: begin
        if (lp != `DSL_LP_MARK1) begin
          cnt_nxt = 20'(WAKEUP_CYC - 1);
        end else if (cnt_zero) begin
          st_nxt = ST_ULPS_WAKE;
        end
      end
      ST_ULPS_WAKE: begin
        if (stop_long) st_nxt = ST_STOP;
        else if (is_space) st_nxt = ST_ULPS;
      end
      ST_TX: if (tx_done) st_nxt = ST_STOP;
      default: st_nxt = ST_STOP;
    endcase
    if (stop_long && st_r != ST_ULPS && st_r != ST_ULPS_WAKE && st_r != ST_INIT
        && st_r != ST_TX) begin
      st_nxt = ST_STOP;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= ST_INIT;
      cnt_r <= 20'h0;
    end else if (ce) begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Spaced one-hot symbol decode; a mark only counts once a space follows
  wire in_esc = (st_r == ST_ESC_CMD) || (st_r == ST_LPDT);
  always_ff @(posedge clk) begin
    if (reset || (ce && !in_esc)) begin
      mark_r <= 1'b0;
      mark_val_r <= 1'b0;
      bit_cnt_r <= 4'h0;
      sh_r <= 8'h00;
    end else if (ce) begin
      if (is_mark) begin
        mark_r <= 1'b1;
        mark_val_r <= lp[1];
      end else if (sym_bit) begin
        mark_r <= 1'b0;
        sh_r <= cur_byte;
        bit_cnt_r <= byte_done ? 4'h0 : bit_cnt_r + 4'h1;
      end
    end
  end

  // ==========================================================
  // HS deserialiser and its byte crossing
  logic hs_en_r;
  logic rst_r;
  logic [7:0] hs_byte;
  logic hs_tog, tog_s1_r, tog_s2_r, tog_s3_r;
  logic pend_v_r, prev_v_r, last_bit_r;
  logic [7:0] pend_r;
  logic [7:0] age_r;

  dsl_hs_rx u_hs_rx (
    .link_clk(link_clk),
    .reset(rst_r),
    .hs_en(hs_en_r),
    .hs_data(hs_data),
    .byte_data(hs_byte),
    .byte_tog(hs_tog)
  );

  // Registered reset for the link side, clean edge for its async input
  always_ff @(posedge clk) begin
    rst_r <= reset;
  end

  always_ff @(posedge clk) begin
    tog_s1_r <= hs_tog;
    tog_s2_r <= tog_s1_r;
    tog_s3_r <= tog_s2_r;
  end

  wire hs_new = (tog_s2_r != tog_s3_r) && (st_r == ST_HS_RX);
  wire hs_exit = (st_r == ST_HS_RX) && (st_nxt == ST_STOP);
  // Trailer is the inverted last bit held; also drop bytes inside skip
  wire pend_trailer = prev_v_r && (pend_r == {8{!last_bit_r}});
  wire pend_keep = pend_v_r && (age_r == 8'h00) && !pend_trailer;

  // One byte is held back until the next arrives or the burst ends
  always_ff @(posedge clk) begin
    if (reset || (ce && st_r != ST_HS_RX)) begin
      pend_v_r <= 1'b0;
      prev_v_r <= 1'b0;
      last_bit_r <= 1'b0;
      age_r <= 8'h00;
    end else if (ce) begin
      if (hs_new) begin
        pend_r <= hs_byte;
        pend_v_r <= 1'b1;
        age_r <= 8'(SKIP_CYC);
        prev_v_r <= pend_v_r;
        if (pend_v_r) last_bit_r <= pend_r[7];
      end else if (age_r != 8'h00) begin
        age_r <= age_r - 8'h01;
      end
    end
  end

  // ==========================================================
  // Protocol outputs
  wire lp_byte = (st_r == ST_LPDT) && byte_done && !stop_long;
  wire hs_out = (hs_new && pend_v_r) || (hs_exit && pend_keep);

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_o <= '0;
      first_r <= 1'b1;
      hs_en_r <= 1'b0;
      term_en <= 1'b0;
      init_done <= 1'b0;
      ulps_enter <= 1'b0;
      trig_reset <= 1'b0;
    end else if (ce) begin
      rx_o.valid <= lp_byte || hs_out;
      rx_o.sob <= (lp_byte || hs_out) && first_r;
      rx_o.eob <= hs_exit || ((st_r == ST_LPDT) && stop_long);
      rx_o.hs <= (st_r == ST_HS_RX);
      if (lp_byte) rx_o.data <= cur_rev;
      else if (hs_out) rx_o.data <= pend_r;
      if (lp_byte || hs_out) first_r <= 1'b0;
      else if (st_r == ST_STOP) first_r <= 1'b1;
      term_en <= (st_nxt == ST_HS_SETTLE) || (st_nxt == ST_HS_RX);
      hs_en_r <= (st_nxt == ST_HS_RX);
      if (st_r == ST_INIT && st_nxt == ST_STOP) init_done <= 1'b1;
      ulps_enter <= (st_r == ST_ESC_CMD) && (st_nxt == ST_ULPS);
      // The TE code is deliberately not decoded into any other action
      trig_reset <= (st_r == ST_ESC_CMD) && (st_nxt == ST_TRIG_SKIP)
        && (cur_byte == `DSL_CMD_RESET);
    end
  end

  assign ulps_active = (st_r == ST_ULPS) || (st_r == ST_ULPS_WAKE);

  // ==========================================================
  // Reverse escape sender: acknowledge first, tearing event next
  logic [4:0] tx_ph_r;
  logic [7:0] tx_cnt_r;
  logic [7:0] tx_code_r;
  logic [1:0] tx_lvl;
  wire [4:0] bit_ph = tx_ph_r - `DSL_TX_PH_BITS;
  wire [2:0] bit_idx = 3'd7 - bit_ph[3:1];

  // Line level per phase: entry, mark/space pairs, closing mark-1, stop
  assign tx_lvl = (tx_ph_r == 5'h00) ? `DSL_LP_MARK1 :
                  (tx_ph_r == 5'h02) ? `DSL_LP_MARK0 :
                  (tx_ph_r < `DSL_TX_PH_BITS) ? `DSL_LP_SPACE :
                  (tx_ph_r == `DSL_TX_PH_MARK1) ? `DSL_LP_MARK1 :
                  (tx_ph_r == `DSL_TX_PH_STOP) ? `DSL_LP_STOP :
                  bit_ph[0] ? `DSL_LP_SPACE :
                  (tx_code_r[bit_idx] ? `DSL_LP_MARK1 : `DSL_LP_MARK0);
  assign tx_done = tx_act_r && (tx_ph_r == `DSL_TX_PH_STOP) && (tx_cnt_r == 8'h00);

  // Pending requests; a new event in the clearing cycle still wins
  always_ff @(posedge clk) begin
    if (reset) begin
      ack_pend_r <= 1'b0;
      te_pend_r <= 1'b0;
    end else if (ce) begin
      ack_pend_r <= ack_req || (ack_pend_r && !tx_start);
      te_pend_r <= te_event || (te_pend_r && !(tx_start && !ack_pend_r));
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tx_act_r <= 1'b0;
      tx_ph_r <= 5'h00;
      tx_cnt_r <= 8'h00;
      tx_code_r <= 8'h00;
      bus_return <= 1'b0;
    end else if (ce) begin
      bus_return <= tx_done;
      if (tx_start) begin
        tx_act_r <= 1'b1;
        tx_ph_r <= 5'h00;
        tx_cnt_r <= 8'(LPX_CYC - 1);
        tx_code_r <= ack_pend_r ? `DSL_CMD_ACK : `DSL_CMD_TE;
      end else if (tx_done) begin
        tx_act_r <= 1'b0;
      end else if (tx_act_r && tx_cnt_r == 8'h00) begin
        tx_ph_r <= tx_ph_r + 5'h01;
        tx_cnt_r <= 8'(LPX_CYC - 1);
      end else if (tx_act_r) begin
        tx_cnt_r <= tx_cnt_r - 8'h01;
      end
    end
  end

  assign lp_drv = '{dp: tx_act_r & tx_lvl[1], dn: tx_act_r & tx_lvl[0], oe: tx_act_r};

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_lpdt_stop;
    (st_r == ST_LPDT) && stop_long && ce;
  endsequence

  chk_trig_skip_quiet: assert property (
    (st_r == ST_TRIG_SKIP)[*2] |-> !rx_o.valid)
    else $error("byte delivered after trigger command");
  chk_lpdt_pause: assert property (
    (st_r == ST_LPDT) && is_space && !mark_r && ce |=> (st_r == ST_LPDT) && !rx_o.valid)
    else $error("space in LPDT not taken as pause");
  chk_lpdt_end: assert property (
    s_lpdt_stop |=> (st_r == ST_STOP) && rx_o.eob && !rx_o.valid)
    else $error("stop did not end LPDT");
  chk_mark_nobit: assert property (
    (st_r == ST_LPDT) && mark_r && is_stop |-> !lp_byte)
    else $error("closing mark counted as bit");
  chk_ulps_entry: assert property (
    ulps_enter |-> ulps_active && !lp_drv.oe)
    else $error("ULPS flag without ULPS state");
  chk_ulps_exit: assert property (
    $past(st_r) == ST_ULPS && st_r != ST_ULPS |-> st_r == ST_ULPS_WAKE)
    else $error("ULPS left without wakeup mark");
  chk_return_after: assert property (
    bus_return |-> !tx_act_r && $past(lp_drv.dp) && $past(lp_drv.dn))
    else $error("bus returned before stop was driven");
  chk_term_settle: assert property (
    $rose(hs_en_r) |-> term_en && $past(term_en))
    else $error("HS receiver on before termination settled");
  chk_init_long: assert property (
    $rose(init_done) |-> $past(init_cnt_r) == 20'h0 && $past(is_stop))
    else $error("init done without long stop");
  chk_escape_abort: assert property (
    (st_r == ST_ESC_RQST || st_r == ST_ESC_BRIDGE) && is_stop && ce |=> st_r == ST_STOP)
    else $error("escape entry not aborted by stop");

endmodule : dsl_lane_ctrl

// ===== dsl_pkg.sv
/*
  Types shared by the slave lane control block and its HS deserialiser.
  Assumes the timing header is available for the including files.
*/
package dsl_pkg;

  // ==========================================================
  // Lane receive state, Gray steps along the usual paths
  typedef enum logic [3:0] {
    ST_INIT = 4'h0,
    ST_STOP = 4'h1,
    ST_HS_RQST = 4'h3,
    ST_HS_PREP = 4'h2,
    ST_HS_SETTLE = 4'h6,
    ST_HS_RX = 4'h7,
    ST_ESC_RQST = 4'h5,
    ST_ESC_BRIDGE = 4'h4,
    ST_ESC_MARK0 = 4'hc,
    ST_ESC_CMD = 4'hd,
    ST_LPDT = 4'hf,
    ST_TRIG_SKIP = 4'he,
    ST_ULPS = 4'ha,
    ST_ULPS_WAKE = 4'hb,
    ST_TX = 4'h9
  } dsl_state_t;

  // ==========================================================
  // Byte stream towards the protocol layer
  typedef struct packed {
    logic [7:0] data;
    logic valid;
    logic sob;
    logic eob;
    logic hs;
  } dsl_rx_t;

  // Line drive of the bidirectional lane
  typedef struct packed {
    logic dp;
    logic dn;
    logic oe;
  } dsl_lp_drv_t;

endpackage : dsl_pkg

// ===== tb.sv
/*
  Self-checking bench of one slave data lane against the host model.
  Assumes shortened init and wakeup counts and default LPX of 10 cycles.
*/
`timescale 1ns/100ps
// ==========================================================
// Bench top
module tb;
  logic clk, reset, bus_owned, ack_req, te_event, hdp, hdn, lclk, hsd, bus_return;
  logic term_en, init_done, ulps_active, ulps_enter, trig_reset, tprev, ce;
  dsl_pkg::dsl_lp_drv_t lp_drv;
  dsl_pkg::dsl_rx_t rx_o;
  logic [31:0] gotw;
  int fails, n_checks, ng, nsob, neob, nhs, ntrig, nulps, nterm;
  dsl_host_model h (.clk(clk), .dp(hdp), .dn(hdn), .link_clk(lclk), .hs_data(hsd));
  dsl_lane_ctrl #(.INIT_CYC(50), .WAKEUP_CYC(40)) dut (.clk(clk), .reset(reset), .ce(ce),
    .dp_i(lp_drv.oe ? lp_drv.dp : hdp), .dn_i(lp_drv.oe ? lp_drv.dn : hdn), .lp_drv(lp_drv),
    .link_clk(lclk), .hs_data(hsd), .term_en(term_en), .bus_owned(bus_owned),
    .ack_req(ack_req), .te_event(te_event), .bus_return(bus_return), .rx_o(rx_o),
    .init_done(init_done), .ulps_active(ulps_active), .ulps_enter(ulps_enter),
    .trig_reset(trig_reset));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic int one(input logic b);
    return (b === 1'b1) ? 1 : 0;
  endfunction : one
  // Output monitor; counts only settled ones so unknowns never count
  always @(posedge clk) begin
    if (one(rx_o.valid)) begin
      gotw = {gotw[23:0], rx_o.data};
      ng++;
      nsob += one(rx_o.sob);
      nhs += one(rx_o.hs);
    end
    neob += one(rx_o.eob);
    ntrig += one(trig_reset);
    nulps += one(ulps_enter);
    nterm += one(term_en) & ~one(tprev);
    tprev = term_en;
  end
  task automatic clr();
    {ng, nsob, neob, nhs, ntrig, nulps, nterm} = '0;
  endtask : clr
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  // Bounded wait on oe (1) or bus_return (2)
  task automatic waitfor(input int w, input int lim);
    int i;
    for (i = 0; i < lim && one(w == 1 ? lp_drv.oe : bus_return) == 0; i++) @(negedge clk);
    if (i == lim) begin
      chk("wait", w, 0);
      complete_run();
    end
  endtask : waitfor
  // ==========================================================
  // Scenarios
  task automatic t_init();
    h.lp(2'b00, 20);
    h.lp(2'b11, 30);
    h.lp(2'b00, 20);
    chk("init short stop", 0, init_done);
    h.lp(2'b11, 80);
    chk("init long stop", 1, init_done);
    $display("init done");
  endtask : t_init
  task automatic t_lpdt();
    clr();
    h.esc(8'he1);
    h.lsb(8'h15);
    h.lp(2'b00, 40);
    h.lsb(8'h39);
    h.fin();
    chk("lpdt bytes", 16'h1539, gotw[15:0]);
    chk("lpdt count", 2, ng);
    chk("lpdt sob eob", 32'h00010001, {nsob[15:0], neob[15:0]});
    $display("lpdt done");
  endtask : t_lpdt
  task automatic t_trig();
    int k;
    for (k = 0; k < 2; k++) begin
      clr();
      h.esc(k == 0 ? 8'h62 : 8'h5d);
      h.lsb(8'he1);
      h.fin();
      chk("trigger", k == 0, ntrig);
      chk("bits after trigger", 0, ng);
    end
    $display("trigger done");
  endtask : t_trig
  // A command sent while the clock enable is low must leave no trace
  task automatic t_ce();
    clr();
    ce = 1'b0;
    h.esc(8'h1e);
    ce = 1'b1;
    h.lp(2'b11, 40);
    chk("ce freeze", 0, {nulps[15:0], 15'h0, ulps_active});
    $display("ce done");
  endtask : t_ce
  task automatic t_ulps();
    clr();
    h.esc(8'h1e);
    chk("ulps entry", 32'h10001, {nulps[15:0], 15'h0, ulps_active});
    h.lp(2'b10, 14);
    h.lp(2'b11, 40);
    chk("ulps short mark", 1, ulps_active);
    h.lp(2'b00, 14);
    h.lp(2'b10, 46);
    h.lp(2'b11, 40);
    chk("ulps wake", 0, ulps_active);
    $display("ulps done");
  endtask : t_ulps
  task automatic t_hs();
    clr();
    h.burst(16'h813c);
    chk("hs bytes", 16'h3c81, gotw[15:0]);
    chk("hs flags", 32'h02010101, {ng[7:0], nsob[7:0], neob[7:0], nterm[7:0]});
    chk("hs mode", 2, nhs);
    chk("termination off", 0, term_en);
    $display("hs done");
  endtask : t_hs
  task automatic t_rev(input logic [7:0] code, input logic te);
    int p;
    logic [1:0] e;
    bus_owned = 1'b1;
    te_event = te;
    ack_req = ~te;
    @(negedge clk);
    te_event = 1'b0;
    ack_req = 1'b0;
    waitfor(1, 20);
    for (p = 0; p < 22; p++) begin
      repeat (p == 0 ? 5 : 10) @(negedge clk);
      e = p < 4 ? (p == 0 ? 2'b10 : p == 2 ? 2'b01 : 2'b00) : p > 19 ? {1'b1, p[0]} :
        p[0] ? 2'b00 : (code[7 - (p - 4) / 2] ? 2'b10 : 2'b01);
      chk("reverse phase", e, {lp_drv.dp, lp_drv.dn});
    end
    waitfor(2, 20);
    bus_owned = 1'b0;
    repeat (20) @(negedge clk);
    $display("reverse done");
  endtask : t_rev
  // ==========================================================
  // Main sequence and hang guard
  initial begin
    {reset, ce, bus_owned, ack_req, te_event, tprev} = 6'h30;
    gotw = '0;
    repeat (8) @(negedge clk);
    reset = 1'b0;
    t_init();
    t_lpdt();
    t_trig();
    t_ce();
    t_ulps();
    t_hs();
    t_rev(8'h21, 1'b0);
    t_rev(8'h5d, 1'b1);
    complete_run();
  end
  initial begin
    #400000;
    chk("watchdog", 0, 1);
    complete_run();
  end
endmodule : tb
